//--- core/phyx_ext_ctrl2.sv
/*
 * Extended control register two of the transceiver with its control effects.
 * Assumes a management frame engine that presents one-cycle read and write
 * strobes with a register address, and line/status inputs on the core clock
 * except the two strap pins, which are synchronised here.
 */
// Operation
// - Bit 15 reads the role, node 0 or repeater 1, from the role strap.
// - In node mode the post-transmit collision test is enabled by default.
// - In node mode carrier sense follows transmit or receive activity.
// - Bit 14 is read-only and reads the configuration mode from its strap.
// - In software mode the written register bits govern configuration.
// - Bit 13 is read-only and mirrors the partner's remote fault flag.
// - Bit 7, default 0, puts the transmit pair in high impedance when 1.
// - Bit 0, default 1, powers down the 100 Mb/s transceiver at 10 Mb/s.
// - Isolating the device also powers down the 100 Mb/s transceiver.
// - Reserved bits reset to 0; bit 10 is read-only, others writable.
// - The collision test is suppressed in full duplex and repeater mode.
`timescale 1ns/100ps
module phyx_ext_ctrl2
   import phyx_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_role_strap,
   input wire logic i_cfg_strap,
   input wire logic i_mgmt_wr,
   input wire logic i_mgmt_rd,
   input wire logic [4:0] i_mgmt_addr,
   input wire logic [15:0] i_mgmt_wdata,
   input wire logic i_lp_remote_fault,
   input wire logic i_speed_10,
   input wire logic i_full_duplex,
   input wire logic i_isolate,
   input wire logic i_sqe_inhibit,
   input wire logic i_tx_active,
   input wire logic i_rx_active,
   input wire logic i_line_tx_pos,
   input wire logic i_line_tx_neg,
   output logic [15:0] o_mgmt_rdata,
   output logic o_mgmt_rd_valid,
   output logic o_node_repeater_select,
   output logic o_software_config_mode,
   output logic o_carrier_sense,
   output logic o_sqe_test_enable,
   output logic o_tx100_power_down,
   output logic o_line_tx_pos,
   output logic o_line_tx_pos_oe_n,
   output logic o_line_tx_neg,
   output logic o_line_tx_neg_oe_n
);

   phyx_state_type st_r;
   phyx_state_type st_nxt;
   phyx_mgmt_req_type req;
   logic [15:0] rd_word;
   logic hiz_eff;
   logic apd_eff;

   assign req = '{wr: i_mgmt_wr, rd: i_mgmt_rd, addr: i_mgmt_addr,
                  wdata: i_mgmt_wdata};

   always_comb begin
      st_nxt = st_r;
      st_nxt.role_sync = {st_r.role_sync[0], i_role_strap};
      st_nxt.cfg_sync = {st_r.cfg_sync[0], i_cfg_strap};
      if (st_r.fill != PHYX_SYNC_FILL) begin
         st_nxt.fill = 2'(st_r.fill + 2'h1);
      end
      // Straps are caught once, after both synchroniser stages hold the pin.
      if (!st_r.captured && st_r.fill == PHYX_SYNC_FILL) begin
         st_nxt.captured = 1'b1;
         st_nxt.node_repeater_select = st_r.role_sync[1];
         st_nxt.software_config_mode = st_r.cfg_sync[1];
      end
      // Only writable bits are stored; bits 15 to 13 and 10 ignore writes.
      if (req.wr && req.addr == PHYX_ADDR_EXT_CTRL2) begin
         st_nxt.ctrl = req.wdata & PHYX_WR_MASK;
      end
      rd_word = st_r.ctrl & PHYX_WR_MASK;
      rd_word[PHYX_BIT_ROLE] = st_r.node_repeater_select;
      rd_word[PHYX_BIT_SWMODE] = st_r.software_config_mode;
      rd_word[PHYX_BIT_RFAULT] = i_lp_remote_fault;
      st_nxt.rd_valid = req.rd && req.addr == PHYX_ADDR_EXT_CTRL2;
      if (req.rd && req.addr == PHYX_ADDR_EXT_CTRL2) begin
         st_nxt.rdata = rd_word;
      end
      // Register bits steer the line only in software mode.
      hiz_eff = st_r.software_config_mode
                && st_r.ctrl[PHYX_BIT_HIZ];
      apd_eff = st_r.software_config_mode ? st_r.ctrl[PHYX_BIT_APD]
                : PHYX_CTRL_RST[PHYX_BIT_APD];
      st_nxt.line.line_tx_oe_n = hiz_eff;
      st_nxt.line.line_tx_pos = i_line_tx_pos;
      st_nxt.line.line_tx_neg = i_line_tx_neg;
      st_nxt.line.tx100_power_down = (apd_eff && i_speed_10)
                                     || i_isolate;
      st_nxt.line.carrier_sense = st_r.node_repeater_select ? i_rx_active
                                  : (i_tx_active || i_rx_active);
      st_nxt.line.sqe_test_enable = !st_r.node_repeater_select
                                    && !i_full_duplex
                                    && !i_sqe_inhibit;
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_r <= '0;
         st_r.ctrl <= PHYX_CTRL_RST;
         st_r.line.line_tx_oe_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_mgmt_rdata = st_r.rdata;
   assign o_mgmt_rd_valid = st_r.rd_valid;
   assign o_node_repeater_select = st_r.node_repeater_select;
   assign o_software_config_mode = st_r.software_config_mode;
   assign o_carrier_sense = st_r.line.carrier_sense;
   assign o_sqe_test_enable = st_r.line.sqe_test_enable;
   assign o_tx100_power_down = st_r.line.tx100_power_down;
   assign o_line_tx_pos = st_r.line.line_tx_pos;
   assign o_line_tx_neg = st_r.line.line_tx_neg;
   assign o_line_tx_pos_oe_n = st_r.line.line_tx_oe_n;
   assign o_line_tx_neg_oe_n = st_r.line.line_tx_oe_n;

   // Checks of the register and its effects.
   AST_ROLE_READ: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) o_mgmt_rd_valid
      |-> o_mgmt_rdata[PHYX_BIT_ROLE] == o_node_repeater_select)
      else $error("Role bit does not match role.");
   AST_SQE_NODE: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) (st_r.captured && !o_node_repeater_select
      && !i_full_duplex && !i_sqe_inhibit) |=> o_sqe_test_enable)
      else $error("Collision test not enabled in node mode.");
   AST_CRS_NODE: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) (st_r.captured && !o_node_repeater_select
      && $rose(o_node_repeater_select) == 1'b0 && i_tx_active)
      |=> o_carrier_sense)
      else $error("Carrier sense missed transmit activity.");
   AST_SW_RO: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) st_r.captured |=> $stable(o_software_config_mode))
      else $error("Configuration mode changed after capture.");
   AST_RFAULT: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) (i_mgmt_rd && i_mgmt_addr == PHYX_ADDR_EXT_CTRL2)
      |=> o_mgmt_rd_valid && o_mgmt_rdata[PHYX_BIT_RFAULT]
          == $past(i_lp_remote_fault))
      else $error("Remote fault bit does not mirror partner.");
   AST_HIZ: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) (o_software_config_mode
      && st_r.ctrl[PHYX_BIT_HIZ]) |=> o_line_tx_pos_oe_n && o_line_tx_neg_oe_n)
      else $error("Transmit pair driven while tri-state set.");
   AST_APD: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) (o_software_config_mode
      && st_r.ctrl[PHYX_BIT_APD] && i_speed_10) |=> o_tx100_power_down)
      else $error("No power-down at 10 Mb/s.");
   AST_ISO: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) i_isolate |=> o_tx100_power_down)
      else $error("Isolate did not power down transceiver.");
   AST_RES10: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) o_mgmt_rd_valid |-> !o_mgmt_rdata[10])
      else $error("Read-only reserved bit 10 not zero.");
   AST_SQE_SUPP: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) (i_full_duplex || o_node_repeater_select)
      |=> !o_sqe_test_enable)
      else $error("Collision test not suppressed.");
   AST_CRS_NODE_RX: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) (st_r.captured && !o_node_repeater_select
      && i_rx_active) |=> o_carrier_sense)
      else $error("Carrier sense missed receive activity.");
   AST_CRS_REP: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) (st_r.captured && o_node_repeater_select)
      |=> o_carrier_sense == $past(i_rx_active))
      else $error("Repeater carrier sense does not follow receive.");
   AST_SQE_INH: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) i_sqe_inhibit
      |=> !o_sqe_test_enable)
      else $error("Collision test enabled while inhibited.");
   AST_HIZ_OFF: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) !(o_software_config_mode && st_r.ctrl[PHYX_BIT_HIZ])
      |=> !o_line_tx_pos_oe_n && !o_line_tx_neg_oe_n)
      else $error("Transmit pair not driven in normal operation.");
   AST_APD_OFF: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) (!i_isolate && !i_speed_10)
      |=> !o_tx100_power_down)
      else $error("Transceiver powered down at 100 Mb/s.");
   AST_HW_APD: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) (st_r.captured && !o_software_config_mode
      && i_speed_10) |=> o_tx100_power_down)
      else $error("Hardware mode did not use default power-down.");
   AST_ROLE_RO: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) st_r.captured
      |=> $stable(o_node_repeater_select))
      else $error("Role changed after capture.");
   AST_SW_READ: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) o_mgmt_rd_valid
      |-> o_mgmt_rdata[PHYX_BIT_SWMODE] == o_software_config_mode)
      else $error("Mode bit does not match configuration mode.");
   AST_NO_RD: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) !(i_mgmt_rd && i_mgmt_addr == PHYX_ADDR_EXT_CTRL2)
      |=> !o_mgmt_rd_valid)
      else $error("Read answered without a read of this register.");
   AST_WR_STORE: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) (i_mgmt_wr && i_mgmt_addr == PHYX_ADDR_EXT_CTRL2)
      |=> st_r.ctrl == ($past(i_mgmt_wdata) & PHYX_WR_MASK))
      else $error("Write not stored in writable bits.");
   AST_HOLD: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) !(i_mgmt_wr && i_mgmt_addr == PHYX_ADDR_EXT_CTRL2)
      |=> $stable(st_r.ctrl))
      else $error("Control changed without a write.");
   AST_RDATA_HOLD: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) !(i_mgmt_rd && i_mgmt_addr == PHYX_ADDR_EXT_CTRL2)
      |=> $stable(o_mgmt_rdata))
      else $error("Read data changed without a read.");
   AST_LINE_POS: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) 1'b1
      |=> o_line_tx_pos == $past(i_line_tx_pos))
      else $error("Positive transmit line not passed through.");
   AST_LINE_NEG: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst) 1'b1
      |=> o_line_tx_neg == $past(i_line_tx_neg))
      else $error("Negative transmit line not passed through.");

endmodule

//--- core/phyx_pkg.sv
/*
 * Package for the extended control and status register of the transceiver.
 * Assumes one 200 MHz core clock and a management frame engine elsewhere.
 */
package phyx_pkg;

   localparam logic [4:0] PHYX_ADDR_EXT_CTRL2 = 5'h13;
   localparam int PHYX_REG_W = 16;

   localparam int PHYX_BIT_ROLE = 15;
   localparam int PHYX_BIT_SWMODE = 14;
   localparam int PHYX_BIT_RFAULT = 13;
   localparam int PHYX_BIT_HIZ = 7;
   localparam int PHYX_BIT_APD = 0;

   // Bits stored on a write: 12, 11, 9, 8, 7 and 6 to 0.
   localparam logic [15:0] PHYX_WR_MASK = 16'h1BFF;
   localparam logic [15:0] PHYX_CTRL_RST = 16'h0001;
   // Edges after reset release until the second synchroniser stage is valid.
   localparam logic [1:0] PHYX_SYNC_FILL = 2'h2;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [15:0] wdata;
   } phyx_mgmt_req_type;

   typedef struct packed {
      logic carrier_sense;
      logic sqe_test_enable;
      logic tx100_power_down;
      logic line_tx_pos;
      logic line_tx_neg;
      logic line_tx_oe_n;
   } phyx_line_type;

   typedef struct packed {
      logic [1:0] role_sync;
      logic [1:0] cfg_sync;
      logic [1:0] fill;
      logic captured;
      logic node_repeater_select;
      logic software_config_mode;
      logic [15:0] ctrl;
      logic [15:0] rdata;
      logic rd_valid;
      phyx_line_type line;
   } phyx_state_type;

endpackage

//--- tb/phyx_mgmt_model.sv
/* Model of the management entity that issues register strobes.
   Assumes the core clock of the register block. */
`timescale 1ns/100ps
module phyx_mgmt_model
   import phyx_pkg::*;
(
   input wire logic i_core_clk,
   output phyx_mgmt_req_type o_req
);
   initial o_req = '0;
   // One-cycle strobe; writes pass the data word through unchanged.
   task automatic access(input logic wr, input logic [4:0] addr,
         input logic [15:0] data);
      @(posedge i_core_clk);
      o_req <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
      @(posedge i_core_clk);
      o_req <= '0;
      #1;
   endtask
endmodule

//--- tb/phyx_ext_ctrl2_test.sv
/* Self-checking bench for extended control register two.
   Assumes the management model drives the register strobes. */
`timescale 1ns/100ps
module phyx_ext_ctrl2_test
   import phyx_pkg::*;
;
   logic i_core_clk = 0, i_sys_rst = 1, rf = 0, spd = 0, fdx = 0, iso = 0;
   logic tx = 0, rx = 0, tp = 0, tn = 0, rs = 0, cf = 1, inh = 0;
   logic [15:0] rdata;
   logic rv, nr, sw, cs, sqe, pd, op, opn, on, onn;
   phyx_mgmt_req_type req;
   int errors = 0, n_tests = 0;
   localparam logic [4:0] A = PHYX_ADDR_EXT_CTRL2;
   initial forever #2.5 i_core_clk = ~i_core_clk;
   phyx_mgmt_model phyx_mgmt_model_inst (.i_core_clk(i_core_clk),
      .o_req(req));
   phyx_ext_ctrl2 phyx_ext_ctrl2_inst (.i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst), .i_role_strap(rs), .i_cfg_strap(cf),
      .i_mgmt_wr(req.wr), .i_mgmt_rd(req.rd), .i_mgmt_addr(req.addr),
      .i_mgmt_wdata(req.wdata), .i_lp_remote_fault(rf), .i_speed_10(spd),
      .i_full_duplex(fdx), .i_isolate(iso), .i_sqe_inhibit(inh),
      .i_tx_active(tx), .i_rx_active(rx), .i_line_tx_pos(tp),
      .i_line_tx_neg(tn), .o_mgmt_rdata(rdata), .o_mgmt_rd_valid(rv),
      .o_node_repeater_select(nr), .o_software_config_mode(sw),
      .o_carrier_sense(cs), .o_sqe_test_enable(sqe),
      .o_tx100_power_down(pd), .o_line_tx_pos(op),
      .o_line_tx_pos_oe_n(opn), .o_line_tx_neg(on),
      .o_line_tx_neg_oe_n(onn));
   task automatic chk(input string name, input logic [15:0] e, g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", name, e, g);
      end
   endtask
   task automatic rd(input logic [15:0] e);
      phyx_mgmt_model_inst.access(1'b0, A, 16'h0000);
      chk("rd_valid", 16'h0001, {15'h0000, rv});
      chk("rdata", e, rdata);
   endtask
   task automatic wr(input logic [15:0] d);
      phyx_mgmt_model_inst.access(1'b1, A, d);
   endtask
   task automatic settle;
      repeat (2) @(posedge i_core_clk);
      #1;
   endtask
   task automatic t_reset;
      rd(16'h4001);
      chk("modes", 16'h0001, {14'h0000, nr, sw});
   endtask
   task automatic t_write;
      wr(16'h0081);
      rd(16'h4081);
      settle();
      chk("hiz", 16'h0003, {14'h0000, opn, onn});
      wr(16'hE001);
      rd(16'h4001);
      @(posedge i_core_clk);
      tp <= 1'b1;
      settle();
      chk("line", 16'h0008, {12'h000, op, on, opn, onn});
      @(posedge i_core_clk);
      tp <= 1'b0;
      tn <= 1'b1;
      settle();
      chk("line_neg", 16'h0004, {12'h000, op, on, opn, onn});
   endtask
   task automatic t_power;
      @(posedge i_core_clk);
      spd <= 1'b1;
      settle();
      chk("apd_on", 16'h0001, {15'h0000, pd});
      wr(16'h0000);
      settle();
      chk("apd_off", 16'h0000, {15'h0000, pd});
      @(posedge i_core_clk);
      iso <= 1'b1;
      settle();
      chk("isolate", 16'h0001, {15'h0000, pd});
      @(posedge i_core_clk);
      iso <= 1'b0;
      wr(16'h0001);
   endtask
   task automatic t_activity;
      @(posedge i_core_clk);
      tx <= 1'b1;
      settle();
      chk("cs_sqe_tx", 16'h0003, {14'h0000, cs, sqe});
      @(posedge i_core_clk);
      tx <= 1'b0;
      rx <= 1'b1;
      fdx <= 1'b1;
      settle();
      chk("cs_sqe_fdx", 16'h0002, {14'h0000, cs, sqe});
      @(posedge i_core_clk);
      fdx <= 1'b0;
      inh <= 1'b1;
      settle();
      chk("cs_sqe_inh", 16'h0002, {14'h0000, cs, sqe});
   endtask
   task automatic t_fault;
      @(posedge i_core_clk);
      rf <= 1'b1;
      rd(16'h6001);
      phyx_mgmt_model_inst.access(1'b0, 5'h12, 16'h0000);
      chk("unmapped", 16'h0000, {15'h0000, rv});
   endtask
   task automatic t_repeater;
      @(posedge i_core_clk);
      i_sys_rst <= 1'b1;
      rs <= 1'b1;
      cf <= 1'b0;
      tx <= 1'b1;
      rx <= 1'b0;
      inh <= 1'b0;
      repeat (5) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      rd(16'hA001);
      chk("modes_rep", 16'h0002, {14'h0000, nr, sw});
      chk("repeater", 16'h0000, {14'h0000, cs, sqe});
      wr(16'h0080);
      rd(16'hA080);
      settle();
      chk("hw_mode", 16'h0001, {13'h0000, opn, onn, pd});
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      t_reset();
      t_write();
      t_power();
      t_activity();
      t_fault();
      t_repeater();
      stop_test();
   end
endmodule
